// File: common/oir_pkg.sv
// Package for the object indication reporter: register map, fields and carriers
package oir_pkg;

	// Register byte offsets
	localparam logic [11:0] OIR_OFS_RCV_CFG = 12'h000;
	localparam logic [11:0] OIR_OFS_SND_CFG = 12'h004;
	localparam logic [11:0] OIR_OFS_STATUS = 12'h008;

	// Reset values
	localparam logic [15:0] OIR_RCV_CFG_RST = 16'h0000;
	localparam logic [15:0] OIR_SND_CFG_RST = 16'h0000;

	// Writable bit masks; reserved bits are never stored
	localparam logic [15:0] OIR_RCV_CFG_MASK = 16'h9803;
	localparam logic [15:0] OIR_SND_CFG_MASK = 16'h00c7;

	// Receive-condition configuration bit positions
	localparam int OIR_RCV_GLOBAL = 0;
	localparam int OIR_RCV_WITH_VALUE = 1;
	localparam int OIR_RCV_ON_RECEIVED = 11;
	localparam int OIR_RCV_ON_CHANGED = 12;
	localparam int OIR_RCV_ON_TIMEOUT = 15;

	// Send-condition configuration: timer usage select
	localparam int OIR_SND_RCV_TIMER = 6;

	// Global flag byte bit positions
	localparam int OIR_GF_RESTART = 0;
	localparam int OIR_GF_UPDATE = 3;
	localparam int OIR_GF_CHANGED = 4;
	localparam int OIR_GF_IP_TIMEOUT = 6;
	localparam int OIR_GF_RCV_TIMEOUT = 7;
	localparam logic [7:0] OIR_GF_MASK = 8'hd9;

	// Device-state byte bit positions
	localparam int OIR_DS_TRANSPARENT = 0;
	localparam int OIR_DS_APP_LOADED = 1;
	localparam int OIR_DS_APP_RUNNING = 2;
	localparam int OIR_DS_PROG_MODE = 7;

	// Kind of indication emitted
	typedef enum logic [1:0] {
		OIR_KIND_OBJECT = 2'b00,
		OIR_KIND_GLOBAL = 2'b01,
		OIR_KIND_STATE = 2'b10
	} oir_kind_t;

	// Object update event from the object store
	typedef struct packed {
		logic valid;
		logic received;
		logic changed;
		logic timeout;
		logic [7:0] obj_number;
		logic [7:0] ram_flags;
		logic [31:0] value;
	} oir_event_t;

	// Indication record towards the host link formatter
	typedef struct packed {
		oir_kind_t kind;
		logic [7:0] group_object_number;
		logic [7:0] ram_flags;
		logic value_present;
		logic [31:0] value;
		logic [7:0] info_byte;
	} oir_ind_t;

	// Main registered state of the reporter; the flag and change-watch helpers hold their own
	typedef struct packed {
		logic [15:0] receive_condition_config;
		logic [15:0] send_condition_config;
		logic [31:0] prdata;
		logic ind_valid;
		oir_ind_t ind;
	} oir_state_t;

endpackage : oir_pkg

// File: hdl/oir_sticky.sv
// Sticky flag bank with set-over-clear priority
`timescale 1ns/100ps
module oir_sticky
	import oir_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Control
	input wire logic [W-1:0] i_set,
	input wire logic i_clr,
	// Flags
	output logic [W-1:0] o_q
);

	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// Clear drops old flags, a set in the same cycle survives
	always_comb begin
		q_nxt = (i_clr ? '0 : q_r) | i_set;
	end

	// Flag register
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_q = q_r;

endmodule : oir_sticky

// File: hdl/oir_change_det.sv
// Change detector for a sampled status word
`timescale 1ns/100ps
module oir_change_det
	import oir_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Watched word
	input wire logic [W-1:0] i_val,
	// One-cycle pulse when the word differs from last cycle
	output logic o_changed
);

	logic [W-1:0] prev_r;
	logic [W-1:0] prev_nxt;

	// Follow the word every cycle
	always_comb begin
		prev_nxt = i_val;
	end

	// Previous value; zero after reset so a non-zero start reports once
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			prev_r <= '0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	assign o_changed = (prev_r != i_val);

endmodule : oir_change_det

// File: hdl/oir_reporter.sv
// Object indication reporter: unsolicited object, global and device-state indications
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module oir_reporter
	import oir_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Object update events
	input wire oir_event_t i_evt,
	output logic o_evt_ready,
	// Device status inputs
	input wire logic i_app_restart,
	input wire logic i_transparent_mode,
	input wire logic i_app_loaded,
	input wire logic i_app_running,
	input wire logic i_prog_mode,
	// Indication output
	output oir_ind_t o_ind,
	output logic o_ind_valid,
	input wire logic i_ind_ready
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	oir_state_t s_r;
	oir_state_t s_nxt;
	logic [7:0] state_byte;
	logic state_changed;
	logic state_pend;
	logic [7:0] glob_q;
	logic [7:0] glob_set;
	logic glob_clr;
	logic state_clr;
	logic glob_mode;
	logic evt_take;
	logic evt_trig;
	logic rcv_timer;
	logic out_free;
	logic apb_setup;
	logic apb_access;
	logic addr_ok;
	logic load_obj;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// Status words and event classification

	// Device-state byte built from the status inputs
	always_comb begin
		state_byte = 8'h00;
		state_byte[OIR_DS_TRANSPARENT] = i_transparent_mode;
		state_byte[OIR_DS_PROG_MODE] = i_prog_mode;
		state_byte[OIR_DS_APP_LOADED] = i_app_loaded;
		state_byte[OIR_DS_APP_RUNNING] = i_app_running;
	end

	// Mode and timer selection; reserved bits are masked at write
	assign glob_mode = s_r.receive_condition_config[OIR_RCV_GLOBAL];
	assign rcv_timer = s_r.send_condition_config[OIR_SND_RCV_TIMER];
	assign out_free = !s_r.ind_valid;

	// Event acceptance: global mode only folds flags, single mode needs a free slot
	assign o_evt_ready = glob_mode | (out_free & !state_pend & (glob_q == 8'h00));
	assign evt_take = i_evt.valid & o_evt_ready;

	// Trigger decode from enabled conditions
	assign evt_trig = (i_evt.received & s_r.receive_condition_config[OIR_RCV_ON_RECEIVED])
		| (i_evt.changed & s_r.receive_condition_config[OIR_RCV_ON_CHANGED])
		| (i_evt.timeout & s_r.receive_condition_config[OIR_RCV_ON_TIMEOUT]);

	// Global flag set terms
	always_comb begin
		glob_set = 8'h00;
		glob_set[OIR_GF_RESTART] = i_app_restart;
		if (evt_take && glob_mode) begin
			glob_set[OIR_GF_UPDATE] = i_evt.received
				& s_r.receive_condition_config[OIR_RCV_ON_RECEIVED];
			glob_set[OIR_GF_CHANGED] = i_evt.changed
				& s_r.receive_condition_config[OIR_RCV_ON_CHANGED];
			glob_set[OIR_GF_IP_TIMEOUT] = i_evt.timeout & !rcv_timer
				& s_r.receive_condition_config[OIR_RCV_ON_TIMEOUT];
			glob_set[OIR_GF_RCV_TIMEOUT] = i_evt.timeout & rcv_timer
				& s_r.receive_condition_config[OIR_RCV_ON_TIMEOUT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Pending global flags
	oir_sticky #(.W(8)) u_glob_flags (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_set(glob_set),
		.i_clr(glob_clr),
		.o_q(glob_q)
	);

	// Device-state change watch
	oir_change_det #(.W(8)) u_state_watch (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_val(state_byte),
		.o_changed(state_changed)
	);

	// Pending device-state indication
	oir_sticky #(.W(1)) u_state_pend (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_set(state_changed),
		.i_clr(state_clr),
		.o_q(state_pend)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	assign apb_setup = i_psel & !i_penable;
	assign apb_access = i_psel & i_penable;
	assign addr_ok = (i_paddr == OIR_OFS_RCV_CFG) | (i_paddr == OIR_OFS_SND_CFG)
		| (i_paddr == OIR_OFS_STATUS);

	// Read data mux
	always_comb begin
		case (i_paddr)
			OIR_OFS_RCV_CFG: rd_mux = {16'h0000, s_r.receive_condition_config};
			OIR_OFS_SND_CFG: rd_mux = {16'h0000, s_r.send_condition_config};
			OIR_OFS_STATUS: rd_mux = {16'h0000, glob_q, state_byte};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	assign o_pready = 1'b1;
	assign o_pslverr = apb_access & !addr_ok;
	assign o_prdata = s_r.prdata;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	// Registers, read capture and indication loader
	always_comb begin
		s_nxt = s_r;
		glob_clr = 1'b0;
		state_clr = 1'b0;
		load_obj = 1'b0;
		// Register writes keep only defined bits
		if (apb_access && i_pwrite) begin
			case (i_paddr)
				OIR_OFS_RCV_CFG: s_nxt.receive_condition_config =
					i_pwdata[15:0] & OIR_RCV_CFG_MASK;
				OIR_OFS_SND_CFG: s_nxt.send_condition_config =
					i_pwdata[15:0] & OIR_SND_CFG_MASK;
				default: s_nxt.send_condition_config = s_r.send_condition_config;
			endcase
		end
		// Read data captured at setup, shown in access
		if (apb_setup) begin
			s_nxt.prdata = i_pwrite ? 32'h0000_0000 : rd_mux;
		end
		// Host took the indication
		if (s_r.ind_valid && i_ind_ready) begin
			s_nxt.ind_valid = 1'b0;
		end
		// Unsolicited emission: state, then global, then object
		if (out_free) begin
			if (state_pend) begin
				s_nxt.ind_valid = 1'b1;
				s_nxt.ind = '0;
				s_nxt.ind.kind = OIR_KIND_STATE;
				s_nxt.ind.info_byte = state_byte;
				state_clr = 1'b1;
			end else if (glob_q != 8'h00) begin
				s_nxt.ind_valid = 1'b1;
				s_nxt.ind = '0;
				s_nxt.ind.kind = OIR_KIND_GLOBAL;
				s_nxt.ind.info_byte = glob_q & OIR_GF_MASK;
				glob_clr = 1'b1;
			end else if (evt_take && !glob_mode && evt_trig) begin
				load_obj = 1'b1;
				s_nxt.ind_valid = 1'b1;
				s_nxt.ind.kind = OIR_KIND_OBJECT;
				s_nxt.ind.group_object_number = i_evt.obj_number;
				s_nxt.ind.ram_flags = i_evt.ram_flags;
				s_nxt.ind.value_present =
					s_r.receive_condition_config[OIR_RCV_WITH_VALUE];
				s_nxt.ind.value = s_r.receive_condition_config[OIR_RCV_WITH_VALUE]
					? i_evt.value : 32'h0000_0000;
				s_nxt.ind.info_byte = 8'h00;
			end
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s_r <= '0;
			s_r.receive_condition_config <= OIR_RCV_CFG_RST;
			s_r.send_condition_config <= OIR_SND_CFG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_ind = s_r.ind;
	assign o_ind_valid = s_r.ind_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	AST_OBJ_ONLY_SINGLE: assert property (
		(out_free && !state_pend && glob_q == 8'h00 && i_evt.valid && evt_trig && !glob_mode)
		|=> (o_ind_valid && o_ind.kind == OIR_KIND_OBJECT))
		else $error("per-object event did not produce an object indication");

	AST_NO_OBJ_IN_GLOBAL: assert property (
		$rose(o_ind_valid) && o_ind.kind == OIR_KIND_OBJECT
		|-> !$past(s_r.receive_condition_config[OIR_RCV_GLOBAL]))
		else $error("object indication emitted in global mode");

	AST_VALUE_FORMAT: assert property (
		load_obj |=> (o_ind.value_present == $past(s_r.receive_condition_config[1])))
		else $error("value presence does not follow receive config");

	AST_NO_TRIGGER: assert property (
		(evt_take && !glob_mode && !evt_trig && !state_pend && glob_q == 8'h00)
		|=> !o_ind_valid)
		else $error("indication without an enabled condition");

	AST_HOLD: assert property (
		(o_ind_valid && !i_ind_ready) |=> (o_ind_valid && $stable(o_ind)))
		else $error("indication changed before it was taken");

	AST_GLOBAL_BITS: assert property (
		(o_ind_valid && o_ind.kind == OIR_KIND_GLOBAL)
		|-> ((o_ind.info_byte & ~OIR_GF_MASK) == 8'h00 && o_ind.info_byte != 8'h00))
		else $error("global flag byte uses undefined bits or is empty");

	AST_TIMEOUT_SEL: assert property (
		(evt_take && glob_mode && i_evt.timeout && s_r.receive_condition_config[15]
		&& s_r.send_condition_config[6])
		|=> (glob_q[OIR_GF_RCV_TIMEOUT] || (o_ind.info_byte[OIR_GF_RCV_TIMEOUT]
		&& o_ind.kind == OIR_KIND_GLOBAL)))
		else $error("receive timeout not flagged in bit 7");

	AST_STATE_REPORT: assert property (
		$changed(state_byte) && !state_pend |-> ##[1:3] state_pend || o_ind_valid)
		else $error("device-state change not reported");

	AST_STATE_BITS: assert property (
		($rose(o_ind_valid) && o_ind.kind == OIR_KIND_STATE)
		|-> (o_ind.info_byte == $past(state_byte)))
		else $error("device-state indication does not match the status inputs");

	AST_OBJ_FIELDS: assert property (
		load_obj |=> (o_ind.group_object_number == $past(i_evt.obj_number)
		&& o_ind.ram_flags == $past(i_evt.ram_flags)))
		else $error("object number or flags not carried");

	AST_RESERVED_ZERO: assert property (
		(s_r.receive_condition_config & ~OIR_RCV_CFG_MASK) == 16'h0000)
		else $error("reserved receive config bits stored");

	COV_OBJECT: cover property (o_ind_valid && i_ind_ready && o_ind.kind == OIR_KIND_OBJECT);
	COV_GLOBAL: cover property (o_ind_valid && o_ind.kind == OIR_KIND_GLOBAL);
	COV_STATE: cover property (o_ind_valid && o_ind.kind == OIR_KIND_STATE);
	COV_STALL: cover property (o_ind_valid && !i_ind_ready [*3]);

endmodule : oir_reporter

// File: verif/oir_host_model.sv
// Host-side model that takes indications, at once or after a stall
`timescale 1ns/100ps
module oir_host_model
	import oir_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Indication link
	input wire oir_ind_t i_ind,
	input wire logic i_ind_valid,
	output logic o_ind_ready,
	// Stall length and capture
	input wire logic [3:0] i_stall,
	output oir_ind_t o_last,
	output logic [7:0] o_count
);
	logic [3:0] wait_r;

	////////////////////////////////////////////////////////////////////////////
	// Accept once the pending indication has waited out the stall
	assign o_ind_ready = i_ind_valid && (wait_r >= i_stall);

	// Count waiting cycles and capture what is taken
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wait_r <= 4'h0;
			o_count <= 8'h00;
			o_last <= '0;
		end else if (o_ind_ready) begin
			wait_r <= 4'h0;
			o_count <= o_count + 8'h01;
			o_last <= i_ind;
		end else if (i_ind_valid) begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule : oir_host_model

// File: verif/tb_oir_reporter.sv
// Testbench for the object indication reporter
`timescale 1ns/100ps
module tb_oir_reporter;
	import oir_pkg::*;
	typedef struct packed {
		logic [15:0] cfg;
		logic [7:0] snd;
		logic [2:0] evk;
		logic pulse;
		logic [3:0] st;
		logic hit;
		oir_kind_t kind;
		logic [7:0] info;
		logic vp;
	} oir_row_t;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, restart = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, evt_rdy, ivalid, iready, e;
	logic [3:0] st = '0, stall = '0;
	logic [7:0] cnt, base;
	oir_event_t evt = '0;
	oir_ind_t ind, last;
	oir_row_t r;
	int n_errors = 0, n_tests = 0;
	oir_row_t rows [14] = '{
		'{16'h0800, 8'h00, 3'b100, 1'b0, 4'h0, 1'b1, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h0802, 8'h00, 3'b100, 1'b0, 4'h0, 1'b1, OIR_KIND_OBJECT, 8'h00, 1'b1},
		'{16'h1000, 8'h00, 3'b010, 1'b0, 4'h0, 1'b1, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h1000, 8'h00, 3'b100, 1'b0, 4'h0, 1'b0, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h8000, 8'h00, 3'b001, 1'b0, 4'h0, 1'b1, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h0800, 8'h00, 3'b001, 1'b0, 4'h0, 1'b0, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h67fc, 8'h00, 3'b111, 1'b0, 4'h0, 1'b0, OIR_KIND_OBJECT, 8'h00, 1'b0},
		'{16'h9801, 8'h00, 3'b110, 1'b0, 4'h0, 1'b1, OIR_KIND_GLOBAL, 8'h18, 1'b0},
		'{16'h9801, 8'h00, 3'b001, 1'b0, 4'h0, 1'b1, OIR_KIND_GLOBAL, 8'h40, 1'b0},
		'{16'h9801, 8'h40, 3'b001, 1'b0, 4'h0, 1'b1, OIR_KIND_GLOBAL, 8'h80, 1'b0},
		'{16'h9801, 8'h00, 3'b000, 1'b1, 4'h0, 1'b1, OIR_KIND_GLOBAL, 8'h01, 1'b0},
		'{16'h0000, 8'h00, 3'b000, 1'b0, 4'h1, 1'b1, OIR_KIND_STATE, 8'h01, 1'b0},
		'{16'h0000, 8'h00, 3'b000, 1'b0, 4'h7, 1'b1, OIR_KIND_STATE, 8'h07, 1'b0},
		'{16'h0000, 8'h00, 3'b000, 1'b0, 4'hf, 1'b1, OIR_KIND_STATE, 8'h87, 1'b0}
	};

	////////////////////////////////////////////////////////////////////////////
	// Design and host model
	oir_reporter u_dut (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_evt(evt), .o_evt_ready(evt_rdy),
		.i_app_restart(restart), .i_transparent_mode(st[0]), .i_app_loaded(st[1]),
		.i_app_running(st[2]), .i_prog_mode(st[3]), .o_ind(ind), .o_ind_valid(ivalid),
		.i_ind_ready(iready));
	oir_host_model u_host (.i_clk_sys(clk), .i_reset(rst), .i_ind(ind), .i_ind_valid(ivalid),
		.o_ind_ready(iready), .i_stall(stall), .o_last(last), .o_count(cnt));

	////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Verdict and end of run
	task automatic report_and_stop;
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// One APB transfer, held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// One object event, held until ready is seen high at a rising edge
	task automatic send(input logic [2:0] k, input logic [7:0] n);
		evt <= '{1'b1, k[2], k[1], k[0], n, 8'h10, 32'h0000_0032};
		do begin
			@(posedge clk);
		end while (evt_rdy !== 1'b1);
		evt.valid <= 1'b0;
	endtask : send

	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OIR_OFS_RCV_CFG, '0);
		chk("rcv reset", q, 32'h0000_0000);
		apb(1'b1, OIR_OFS_RCV_CFG, 32'hffff_ffff);
		apb(1'b0, OIR_OFS_RCV_CFG, '0);
		chk("rcv mask", q, 32'h0000_9803);
		apb(1'b1, OIR_OFS_SND_CFG, 32'hffff_ffff);
		apb(1'b0, OIR_OFS_SND_CFG, '0);
		chk("snd mask", q, 32'h0000_00c7);
		apb(1'b0, 12'h00c, '0);
		chk("unmapped", {e, q}, 33'h1_0000_0000);
		foreach (rows[i]) begin
			r = rows[i];
			base = cnt;
			apb(1'b1, OIR_OFS_RCV_CFG, {16'h0000, r.cfg});
			apb(1'b1, OIR_OFS_SND_CFG, {24'h000000, r.snd});
			@(posedge clk);
			st <= r.st;
			restart <= r.pulse;
			@(posedge clk);
			restart <= 1'b0;
			if (r.evk != 3'b000) send(r.evk, 8'(i + 1));
			repeat (8) @(posedge clk);
			chk("count", cnt - base, {7'h00, r.hit});
			if (r.hit && r.kind == OIR_KIND_OBJECT) begin
				chk("kind", last.kind, r.kind);
				chk("number", last.group_object_number, 8'(i + 1));
				chk("flags", last.ram_flags, 8'h10);
				chk("value", {last.value_present, last.value}, r.vp ? 33'h1_0000_0032 : '0);
			end else if (r.hit) begin
				chk("kind", last.kind, r.kind);
				chk("info", last.info_byte, r.info);
			end
		end
		// Slow host while a second event waits behind the held first indication
		stall <= 4'h5;
		apb(1'b1, OIR_OFS_RCV_CFG, 32'h0000_0802);
		base = cnt;
		send(3'b100, 8'h21);
		repeat (3) @(negedge clk);
		chk("held", {ivalid, ind.group_object_number}, 9'h121);
		chk("busy", evt_rdy, 1'b0);
		@(posedge clk);
		send(3'b100, 8'h22);
		repeat (20) @(posedge clk);
		chk("pair", cnt - base, 8'h02);
		chk("second", {last.group_object_number, last.value}, 40'h22_0000_0032);
		apb(1'b0, OIR_OFS_STATUS, '0);
		chk("state", q[7:0], 8'h87);
		// Reset in mid-run: valid, error and read data clear while pready stays high, then the non-zero state byte reports once
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("in reset", {ivalid, pready, pslverr, prdata}, 35'h2_0000_0000);
		rst <= 1'b0;
		repeat (20) @(posedge clk);
		chk("reset state", {cnt, last.kind, last.info_byte}, {8'h01, OIR_KIND_STATE, 8'h87});
		apb(1'b0, OIR_OFS_RCV_CFG, '0);
		chk("reset cfg", q, 32'h0000_0000);
		report_and_stop();
	end
endmodule : tb_oir_reporter
